// file: logic/vic_edge_detect.sv
module vic_edge_detect
  import vic_pkg::*;
#(
  parameter bit BOTH_EDGES = 1'b0
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      edge_pulse
);

  logic pin_reg;

  // idle level is high, so reset cannot fake a falling edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_reg <= RST_PIN;
    end else begin
      pin_reg <= pin;
    end
  end

  always_comb begin
    if (BOTH_EDGES) begin
      edge_pulse = pin_reg ^ pin;
    end else begin
      edge_pulse = pin_reg & ~pin;
    end
  end

endmodule

// file: logic/vic_pkg.sv
package vic_pkg;

  // ------------------------------------------------------------
  // sources, in priority order (index 0 is served first)
  // ------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam int SRC_EXT = 0;
  localparam int SRC_ADC = 5;

  // ------------------------------------------------------------
  // vectors: source i calls VEC_BASE + i * VEC_STEP
  // ------------------------------------------------------------
  localparam logic [7:0] VEC_BASE = 8'h04;
  localparam logic [7:0] VEC_STEP = 8'h04;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_MASTER = 0;
  localparam int BIT_ST_VEC = 0;
  localparam int BIT_ST_PEND = 8;
  // enable and flag bit of each source inside its control register
  localparam int EN_POS  [NUM_SRC] = '{1, 2, 3, 0, 1, 2};
  localparam int FLG_POS [NUM_SRC] = '{4, 5, 6, 4, 5, 6};
  // which control register holds the source: 0 or 1
  localparam logic SRC_REG [NUM_SRC] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [5:0] RST_EN    = 6'h00;
  localparam logic [5:0] RST_FLAG  = 6'h00;
  localparam logic       RST_MASTER = 1'b0;
  localparam logic       RST_PIN   = 1'b1;

  // ------------------------------------------------------------
  // bus encodings
  // ------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// file: logic/vic_top.sv
// Local design decisions: the AHB-Lite register port and the register addresses.
module vic_top
  import vic_pkg::*;
#(
  parameter bit BOTH_EDGES = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cycle_phase_two,
  input  wire logic        stack_full,
  input  wire logic        ext_irq_pin,
  input  wire logic [3:0]  tmr_overflow,
  input  wire logic        adc_request,
  input  wire logic        core_powered_down,
  input  wire logic        reti_exec,
  output logic             call_req,
  output logic [7:0]       call_vector,
  output logic             pc_push,
  output logic             pc_pop,
  output logic             wake_req
);

  logic [5:0]  enable_reg;
  logic [5:0]  flag_reg;
  logic        master_irq_enable;
  logic [5:0]  hw_set;
  logic [5:0]  pending;
  logic [5:0]  grant;
  logic        take;
  logic        ext_edge;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        addr_ok;
  logic [31:0] rd_next;
  logic [7:0]  vec_next;
  logic [7:0]  last_vec_reg;
  logic        call_reg;
  logic        push_reg;
  logic        pop_reg;
  logic        wake_reg;
  logic [31:0] rdata_reg;

  // ------------------------------------------------------------
  // request sources
  // ------------------------------------------------------------
  vic_edge_detect #(
    .BOTH_EDGES (BOTH_EDGES)
  ) u_edge (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin        (ext_irq_pin),
    .edge_pulse (ext_edge)
  );

  assign hw_set = {adc_request, tmr_overflow, ext_edge};

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  // master gates every call request (not wake), stack full holds the request back
  assign pending = (master_irq_enable && !stack_full) ? (flag_reg & enable_reg)
                                                      : 6'h00;

  always_comb begin
    grant    = 6'h00;
    vec_next = VEC_BASE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        grant    = 6'h00;
        grant[i] = 1'b1;
        vec_next = 8'(VEC_BASE + 8'(i) * VEC_STEP);
      end
    end
  end

  // one decision per instruction cycle
  assign take = cycle_phase_two && (pending != 6'h00);

  // ------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // ------------------------------------------------------------
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend_reg <= addr_ok && hwrite;
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_CTRL0: begin
        rd_next[BIT_MASTER] = master_irq_enable;
        for (int i = 0; i < NUM_SRC; i++) begin
          if (!SRC_REG[i]) begin
            rd_next[EN_POS[i]]  = enable_reg[i];
            rd_next[FLG_POS[i]] = flag_reg[i];
          end
        end
      end
      OFS_CTRL1: begin
        for (int i = 0; i < NUM_SRC; i++) begin
          if (SRC_REG[i]) begin
            rd_next[EN_POS[i]]  = enable_reg[i];
            rd_next[FLG_POS[i]] = flag_reg[i];
          end
        end
      end
      OFS_STATUS: begin
        rd_next[BIT_ST_VEC +: 8]  = last_vec_reg;
        rd_next[BIT_ST_PEND +: 6] = pending;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (addr_ok && !hwrite) begin
        rdata_reg <= rd_next;
      end
    end
  end

  // ------------------------------------------------------------
  // enables, flags, master
  // ------------------------------------------------------------
  logic wr_ctrl0;
  logic wr_ctrl1;

  assign wr_ctrl0 = wr_pend_reg && (wr_addr_reg == OFS_CTRL0);
  assign wr_ctrl1 = wr_pend_reg && (wr_addr_reg == OFS_CTRL1);

  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      logic sw_wr;
      assign sw_wr = SRC_REG[g] ? wr_ctrl1 : wr_ctrl0;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          enable_reg[g] <= RST_EN[g];
        end else if (sw_wr) begin
          enable_reg[g] <= hwdata[EN_POS[g]];
        end
      end

      // later assignments win: software, then service, then hardware set
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_reg[g] <= RST_FLAG[g];
        end else begin
          if (sw_wr) begin
            flag_reg[g] <= hwdata[FLG_POS[g]];
          end
          if (take && grant[g]) begin
            flag_reg[g] <= 1'b0;
          end
          if (hw_set[g]) begin
            flag_reg[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // a write that lands with a call loses: the call must block nesting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_irq_enable <= RST_MASTER;
    end else begin
      if (wr_ctrl0) begin
        master_irq_enable <= hwdata[BIT_MASTER];
      end
      if (take) begin
        master_irq_enable <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // core side
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      call_reg     <= 1'b0;
      push_reg     <= 1'b0;
      last_vec_reg <= 8'h00;
    end else begin
      call_reg <= take;
      push_reg <= take;
      if (take) begin
        last_vec_reg <= vec_next;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pop_reg <= 1'b0;
    end else begin
      pop_reg <= reti_exec;
    end
  end

  // wake ignores master so a sleeping core still resumes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= core_powered_down && ((flag_reg & enable_reg) != 6'h00);
    end
  end

  assign hrdata      = rdata_reg;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign call_req    = call_reg;
  assign call_vector = last_vec_reg;
  assign pc_push     = push_reg;
  assign pc_pop      = pop_reg;
  assign wake_req    = wake_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_call_on_phase: assert property (@(posedge hclk) disable iff (!hresetn)
    call_req |-> $past(cycle_phase_two))
    else $error("call without phase-two sample");

  a_ext_priority: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && pending[SRC_EXT]) |=> (call_vector == VEC_BASE))
    else $error("external request lost priority");

  a_adc_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && pending == 6'h20) |=> (call_vector == 8'h18))
    else $error("adc vector wrong");

  a_vec_range: assert property (@(posedge hclk) disable iff (!hresetn)
    call_req |-> (call_vector >= 8'h04 && call_vector <= 8'h18 && call_vector[1:0] == 2'h0))
    else $error("vector out of table");

  a_master_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (!master_irq_enable || stack_full) |=> !call_req)
    else $error("call taken while blocked");

  a_master_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    call_req |-> !master_irq_enable)
    else $error("master enable not cleared on call");

  a_hw_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    hw_set[SRC_EXT] |=> flag_reg[SRC_EXT])
    else $error("hardware set lost");

  a_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (flag_reg[SRC_ADC] && !wr_ctrl1 && !take) |=> flag_reg[SRC_ADC])
    else $error("flag dropped by itself");

  a_push_pairs: assert property (@(posedge hclk) disable iff (!hresetn)
    call_req == pc_push)
    else $error("push not paired with call");

  a_pop_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    reti_exec |=> pc_pop)
    else $error("return did not pop");

  a_pop_only_reti: assert property (@(posedge hclk) disable iff (!hresetn)
    pc_pop |-> $past(reti_exec))
    else $error("pop without return");

  a_call_one_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
    call_req |=> !call_req)
    else $error("call held past one cycle");

  a_ext_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
    (call_req && call_vector == VEC_BASE) |-> $past(enable_reg[SRC_EXT]))
    else $error("external call while disabled");

  a_adc_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
    (call_req && call_vector == 8'h18) |-> $past(enable_reg[SRC_ADC]))
    else $error("adc call while disabled");

  a_tmr1_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && pending[2:0] == 3'h4) |=> (call_vector == 8'h0C))
    else $error("timer 1 vector wrong");

  a_flag_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && grant[SRC_ADC] && !hw_set[SRC_ADC]) |=> !flag_reg[SRC_ADC])
    else $error("serviced flag not cleared");

  a_tmr_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    tmr_overflow[0] |=> flag_reg[SRC_EXT + 1])
    else $error("timer overflow flag not set");

  a_adc_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    adc_request |=> flag_reg[SRC_ADC])
    else $error("adc request flag not set");

  a_wake_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (core_powered_down && (flag_reg & enable_reg) != 6'h00) |=> wake_req)
    else $error("no wake for enabled source");

  a_nest_allowed: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ctrl0 && hwdata[BIT_MASTER] && !take) |=> master_irq_enable)
    else $error("master set was lost");

endmodule

// file: sim/test_vectored_interrupt_controller.sv
module test_vectored_interrupt_controller
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, stack_full, ext_irq_pin, adc_request;
  logic cycle_phase_two, core_powered_down, reti_exec, hreadyout, hresp;
  logic call_req, pc_push, pc_pop, wake_req, hready;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  tmr_overflow;
  logic [7:0]  call_vector;
  logic [31:0] c [2];
  logic [7:0]  vec_tab [NUM_SRC] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  int          errors = 0, check_count = 0, calls = 0;
  assign hready = hreadyout;
  vic_top #(.BOTH_EDGES(1'b0)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cycle_phase_two(cycle_phase_two), .stack_full(stack_full),
    .ext_irq_pin(ext_irq_pin), .tmr_overflow(tmr_overflow), .adc_request(adc_request),
    .core_powered_down(core_powered_down), .reti_exec(reti_exec), .call_req(call_req),
    .call_vector(call_vector), .pc_push(pc_push), .pc_pop(pc_pop), .wake_req(wake_req));
  vic_core_model #(.DEPTH(2)) core (.hclk(hclk), .hresetn(hresetn), .pc_push(pc_push),
    .pc_pop(pc_pop), .cycle_phase_two(cycle_phase_two), .stack_full(stack_full));
  initial begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end
  always @(negedge hclk) if (call_req === 1'b1) calls++;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic fire(input int i);
    @(posedge hclk);
    if (i == SRC_EXT) ext_irq_pin <= 1'b0;
    else if (i == SRC_ADC) adc_request <= 1'b1;
    else tmr_overflow <= 4'h1 << (i - 1);
    @(posedge hclk);
    adc_request <= 1'b0;
    tmr_overflow <= 4'h0;
  endtask
  task automatic wait_call(input logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (call_req !== 1'b1 && n < 40);
    chk("call_req", 32'h1, {31'h0, call_req});
    chk("call_vector", {24'h0, v}, {24'h0, call_vector});
    chk("pc_push", 32'h1, {31'h0, pc_push});
  endtask
  task automatic reti();
    @(posedge hclk);
    reti_exec <= 1'b1;
    @(posedge hclk);
    reti_exec <= 1'b0;
    @(negedge hclk);
    chk("pc_pop", 32'h1, {31'h0, pc_pop});
  endtask
  task automatic no_call();
    int c0;
    c0 = calls;
    repeat (12) @(negedge hclk);
    chk("calls", c0, calls);
  endtask
  task automatic set_master();
    bus(1'b0, OFS_CTRL0, 32'h0);
    bus(1'b1, OFS_CTRL0, r | 32'h1);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    hresetn           = 1'b0;
    hsel              = 1'b0;
    haddr             = 32'h0;
    htrans            = 2'h0;
    hwrite            = 1'b0;
    hsize             = 3'h2;
    hwdata            = 32'h0;
    ext_irq_pin       = 1'b1;
    tmr_overflow      = 4'h0;
    adc_request       = 1'b0;
    core_powered_down = 1'b0;
    reti_exec         = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_CTRL0, 32'h0);
    chk("ctrl0", 32'h0, r);
    bus(1'b0, OFS_CTRL1, 32'h0);
    chk("ctrl1", 32'h0, r);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0, r);
    bus(1'b1, 8'h0C, 32'hFFFFFFFF);
    bus(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, r);
    for (int i = 0; i < NUM_SRC; i++) begin
      c[0] = 32'h1;
      c[1] = 32'h0;
      c[SRC_REG[i]] |= 32'h1 << EN_POS[i];
      bus(1'b1, OFS_CTRL0, c[0]);
      bus(1'b1, OFS_CTRL1, c[1]);
      fire(i);
      wait_call(vec_tab[i]);
      bus(1'b0, OFS_CTRL0, 32'h0);
      chk("ctrl0 after call", c[0] & 32'hFFFFFFFE, r);
      bus(1'b0, OFS_CTRL1, 32'h0);
      chk("ctrl1 after call", c[1], r);
      reti();
    end
    // pin has stayed low since its fall; a rise alone must not set the flag
    @(posedge hclk);
    ext_irq_pin <= 1'b1;
    bus(1'b0, OFS_CTRL0, 32'h0);
    chk("ctrl0 rising pin", 32'h0, r);
    // overflow lands in the very cycle that software clears the flags
    fork
      bus(1'b1, OFS_CTRL0, 32'h0);
      begin
        repeat (2) @(posedge hclk);
        tmr_overflow <= 4'h1;
        @(posedge hclk);
        tmr_overflow <= 4'h0;
      end
    join
    bus(1'b0, OFS_CTRL0, 32'h0);
    chk("ctrl0 set beats clear", 32'h20, r);
    core_powered_down <= 1'b1;
    bus(1'b1, OFS_CTRL0, 32'h7E);
    bus(1'b1, OFS_CTRL1, 32'h77);
    no_call();
    chk("wake_req", 32'h1, {31'h0, wake_req});
    bus(1'b0, OFS_CTRL0, 32'h0);
    chk("ctrl0 kept", 32'h7E, r);
    core_powered_down <= 1'b0;
    for (int k = 0; k < NUM_SRC; k++) begin
      set_master();
      wait_call(vec_tab[k]);
      reti();
    end
    bus(1'b1, OFS_CTRL1, 32'h77);
    set_master();
    wait_call(8'h10);
    set_master();
    wait_call(8'h14);
    set_master();
    no_call();
    reti();
    wait_call(8'h18);
    // reset in mid-run, with a vector and read data still held
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk("call_vector reset", 32'h0, {24'h0, call_vector});
    chk("hrdata reset", 32'h0, hrdata);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_CTRL1, 32'h0);
    chk("ctrl1 reset", 32'h0, r);
    complete_run();
  end
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule

// file: sim/vic_core_model.sv
module vic_core_model
  import vic_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pc_push,
  input  wire logic pc_pop,
  output logic      cycle_phase_two,
  output logic      stack_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_reg;
  logic [3:0] depth_reg;
  // one phase-two pulse every four clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) phase_reg <= 2'h0;
    else phase_reg <= phase_reg + 2'h1;
  end
  assign cycle_phase_two = (phase_reg == 2'h3);
  // shallow stack so that the full case is reached quickly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) depth_reg <= 4'h0;
    else if (pc_push && !pc_pop) depth_reg <= depth_reg + 4'h1;
    else if (pc_pop && !pc_push) depth_reg <= depth_reg - 4'h1;
  end
  assign stack_full = (depth_reg == 4'(DEPTH));
endmodule
